// ### verif/dcm_ctrl_model.sv
// Purpose: controller-side model: link clock, commands, read capture
// Assumes: link clock runs free at 160 ns, commands held across rise
// Notes: beats are sampled 60 ns after each edge, past the sync delay
`include "dcm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module dcm_ctrl_model
  import dcm_pkg::*;
(
  output var logic ck_pin, // link clock
  output var dcm_cmd_s cmd_pin, // command pins
  input wire logic [15:0] dq_o, // read data
  input wire logic dq_oe // data drive enable
);
  // ----------------------------------------------------------------
  // clock and idle command
  // ----------------------------------------------------------------
  // free running: the clock must stay stable in normal operation
  initial begin
    ck_pin = 1'b0;
    cmd_pin = {1'b1, `DCM_CMD_NOP, 3'h0, 13'h0};
    #3;
    forever #80 ck_pin = ~ck_pin;
  end
  // change on the falling edge so pins are stable around the rise
  task automatic issue(input logic [3:0] op, input logic [2:0] ba,
      input logic [12:0] a, input logic cke);
    @(negedge ck_pin);
    cmd_pin <= {cke, op, ba, a};
    @(posedge ck_pin);
    @(negedge ck_pin);
    // address is don't care on nop: scramble it
    cmd_pin <= {cke, `DCM_CMD_NOP, ~ba, ~a};
  endtask
  // ----------------------------------------------------------------
  // read: count rises to first beat, then take eight beats
  // ----------------------------------------------------------------
  task automatic rd(input logic [12:0] a, output int lat,
      output logic [7:0][15:0] bq, output logic oe_end);
    int k;
    lat = 0;
    bq = '0;
    issue(`DCM_CMD_RD, 3'h0, a, 1'b1);
    for (k = 1; k <= 16 && lat == 0; k++) begin
      @(posedge ck_pin);
      #60;
      if (dq_oe === 1'b1) lat = k;
    end
    if (lat != 0) begin
      bq[0] = dq_o;
      for (k = 1; k < 8; k++) begin
        @(ck_pin);
        #60;
        bq[k] = dq_o;
      end
    end
    @(ck_pin);
    #60;
    oe_end = dq_oe;
    // spacing before the next read, counted in link cycles
    repeat (6) @(posedge ck_pin);
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: self-checking bench for the dram mode block
// Assumes: bus answers in one cycle; model owns the link side
// Notes: expected values come from the field layout, not the design
`include "dcm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import dcm_pkg::*;
();
  logic ref_clk, rst_n, cyc, stb, we, wb_ack_o, ck_pin, dq_oe, oe_end;
  logic dqs_o, dqs_oe, arr_rd_req, arr_wr_req, dll_off_o, self_ref_o;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, wb_dat_o, q;
  logic [15:0] dq_o, arr_rd_data;
  logic [7:0][15:0] bq;
  dcm_cmd_s cmd_pin;
  int fail_count, num_checks, rd_cnt, wr_cnt, lat;
  // ----------------------------------------------------------------
  // clock, instances, pulse counters
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;
  dcm_dram_mode_seq dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ck_pin(ck_pin), .cmd_pin(cmd_pin),
    .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe),
    .arr_rd_req(arr_rd_req), .arr_wr_req(arr_wr_req),
    .arr_rd_data(arr_rd_data), .dll_off_o(dll_off_o),
    .self_ref_o(self_ref_o));
  dcm_ctrl_model m (.ck_pin(ck_pin), .cmd_pin(cmd_pin), .dq_o(dq_o),
    .dq_oe(dq_oe));
  always @(posedge ref_clk) begin
    if (arr_rd_req === 1'b1) rd_cnt <= rd_cnt + 1;
    if (arr_wr_req === 1'b1) wr_cnt <= wr_cnt + 1;
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // classic cycle: hold until ack, take data at that edge only
  task automatic wb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) chk("ack", 1, 0);
  endtask
  // mode set, then wait out tMRD and tMOD in link cycles
  task automatic mode_set_cmd(input logic [2:0] ba, input logic [12:0] a);
    m.issue(`DCM_CMD_MRS, ba, a, 1'b1);
    repeat (4) @(posedge ck_pin);
  endtask
  task automatic chk_pat(input logic fill);
    for (int i = 0; i < 8; i++)
      chk("beat", i[0] ? (fill ? 16'hffff : 16'h0101) : 16'h0, bq[i]);
  endtask
  // enter sleep with cke low, leave with cke held high
  task automatic sleep(input logic exp);
    m.issue(`DCM_CMD_REF, 3'h0, 13'h0, 1'b0);
    repeat (2) @(posedge ck_pin);
    chk("self_ref", exp, self_ref_o);
    m.issue(`DCM_CMD_NOP, 3'h0, 13'h0, 1'b1);
    repeat (4) @(posedge ck_pin);
    chk("self_ref exit", 0, self_ref_o);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    wb(1'b1, `DCM_ADR_STATUS, 32'hffffffff);
    wb(1'b0, `DCM_ADR_STATUS, 0);
    chk("status", 32'h8800, q);
    wb(1'b0, `DCM_ADR_CTRL, 0);
    chk("ctrl", 1, q);
    wb(1'b0, 8'h20, 0);
    chk("unmapped", 0, q);
    chk("dll_off", 0, dll_off_o);
    $display("test reset done");
  endtask
  task automatic t_pattern;
    repeat (4) @(posedge ck_pin);
    mode_set_cmd(`DCM_BA_MR3, 13'h004);
    wb(1'b0, `DCM_ADR_MR3, 0);
    chk("mr3", 32'h4, q);
    wb(1'b0, `DCM_ADR_STATUS, 0);
    chk("status", 32'h8801, q & 32'h001fffff);
    m.rd(13'h1000, lat, bq, oe_end);
    chk("latency", 4, lat);
    chk_pat(1'b1);
    chk("oe end", 0, oe_end);
    chk("dqs_oe end", 0, dqs_oe);
    chk("array reads", 0, rd_cnt);
    wb(1'b1, `DCM_ADR_CTRL, 0);
    m.rd(13'h1400, lat, bq, oe_end);
    chk_pat(1'b0);
    sleep(1'b0);
    $display("test pattern done");
  endtask
  task automatic t_exit;
    repeat (4) @(posedge ck_pin);
    mode_set_cmd(`DCM_BA_MR3, 13'h003);
    m.rd(13'h1000, lat, bq, oe_end);
    chk("array reads", 1, rd_cnt);
    chk("array beat", 16'h5a3c, bq[5]);
    m.issue(`DCM_CMD_WR, 3'h0, 13'h0, 1'b1);
    repeat (4) @(posedge ck_pin);
    chk("array writes", 1, wr_cnt);
    $display("test exit done");
  endtask
  task automatic t_dll;
    mode_set_cmd(`DCM_BA_MR1, 13'h001);
    chk("dll_off", 1, dll_off_o);
    wb(1'b0, `DCM_ADR_STATUS, 0);
    chk("status cl4", 32'h680a, q & 32'h001fffff);
    sleep(1'b1);
    mode_set_cmd(`DCM_BA_MR0, 13'h020);
    wb(1'b0, `DCM_ADR_STATUS, 0);
    chk("status", 32'hac02, q & 32'h001fffff);
    m.rd(13'h1000, lat, bq, oe_end);
    chk("latency", 5, lat);
    sleep(1'b1);
    mode_set_cmd(`DCM_BA_MR1, 13'h000);
    chk("dll_off", 0, dll_off_o);
    mode_set_cmd(`DCM_BA_MR0, 13'h120);
    m.rd(13'h1000, lat, bq, oe_end);
    chk("latency", 6, lat);
    $display("test dll done");
  endtask
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 0;
    rst_n = 0;
    {cyc, stb, we, adr, sel, wdat} = '0;
    arr_rd_data = 16'h5a3c;
    {fail_count, num_checks, rd_cnt, wr_cnt} = '0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ck_pin);
    t_reset;
    t_pattern;
    t_exit;
    t_dll;
    finish_test;
  end
  // the run needs about 24 us; allow well over ten times that
  initial begin
    #400000;
    fail_count++;
    $display("[ERR] watchdog exp done got hang");
    finish_test;
  end
endmodule
`default_nettype wire

// ### verilog/dcm_dram_mode_seq.sv
// Purpose: device side of calibration pattern readout and dll-off mode
// Assumes: ck_pin much slower than ref_clk; one read in flight at a time
// Notes: ck and command pins pass two flops; beats on both ck edges
// Function
// - enabled: reads redirected to preloaded pattern
// - pattern starts after additive plus cas latency
// - disabled: reads and writes reach array again
// - dll off while mode_reg_one bit zero set
// - dll-off supports cas latency six only
// - dll-off output one cycle earlier
// - pattern mode: autoprecharge ignored, no sleep
// - lane line zero alternates zero, one
//
// The Wishbone register port and the placing of the registers are this design's own decisions.
`include "dcm_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module dcm_dram_mode_seq
  import dcm_pkg::*;
(
  input wire logic ref_clk, // block clock, 100 MHz
  input wire logic rst_n, // synchronous reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic wb_we_i, // bus write
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // bus acknowledge
  input wire logic ck_pin, // link clock from controller
  input wire dcm_cmd_s cmd_pin, // command and address pins
  output logic [15:0] dq_o, // data out, both lanes
  output logic dq_oe, // data drive enable
  output logic dqs_o, // read strobe out
  output logic dqs_oe, // strobe drive enable
  output logic arr_rd_req, // pulse: array read
  output logic arr_wr_req, // pulse: array write
  input wire logic [15:0] arr_rd_data, // array word, same clock
  output logic dll_off_o, // dll disabled level
  output logic self_ref_o // self-refresh or power-down level
);
  // ----------------------------------------------------------------
  // pin synchronisers and ck edge detect
  // ----------------------------------------------------------------
  logic ck_s1_reg, ck_s2_reg, ck_d_reg;
  dcm_cmd_s cmd_s1_reg, cmd_s2_reg;
  logic cke_d_reg;
  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ck_s1_reg <= 1'b0;
      ck_s2_reg <= 1'b0;
      ck_d_reg <= 1'b0;
      cmd_s1_reg <= '0;
      cmd_s2_reg <= '0;
    end else begin
      ck_s1_reg <= ck_pin;
      ck_s2_reg <= ck_s1_reg;
      ck_d_reg <= ck_s2_reg;
      cmd_s1_reg <= cmd_pin;
      cmd_s2_reg <= cmd_s1_reg;
    end
  end
  logic ck_rise, ck_fall, ck_edge;
  logic [3:0] op;
  logic cmd_live;
  assign ck_rise = ck_s2_reg & ~ck_d_reg;
  assign ck_fall = ~ck_s2_reg & ck_d_reg;
  assign ck_edge = ck_rise | ck_fall;
  assign op = {cmd_s2_reg.cs_n, cmd_s2_reg.ras_n, cmd_s2_reg.cas_n,
               cmd_s2_reg.we_n};
  assign cmd_live = ck_rise & cmd_s2_reg.cke & cke_d_reg;
  // ----------------------------------------------------------------
  // mode registers and decoded commands
  // ----------------------------------------------------------------
  logic [12:0] mr0_reg, mr1_reg, mr3_reg;
  logic mrs_fire, rd_fire, wr_fire;
  logic mpr_en, dll_off;
  assign mrs_fire = cmd_live & (op == `DCM_CMD_MRS);
  assign rd_fire = cmd_live & (op == `DCM_CMD_RD) & ~self_ref_o;
  assign wr_fire = cmd_live & (op == `DCM_CMD_WR) & ~self_ref_o;
  assign mpr_en = mr3_reg[`DCM_MR3_MPR_BIT];
  assign dll_off = mr1_reg[`DCM_MR1_DLL_BIT];
  assign dll_off_o = dll_off;
  // mode register set loads the register the bank bits select
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mr0_reg <= '0;
      mr1_reg <= '0;
      mr3_reg <= '0;
    end else if (mrs_fire) begin
      if (cmd_s2_reg.ba == `DCM_BA_MR0) begin
        mr0_reg <= cmd_s2_reg.addr;
      end else if (cmd_s2_reg.ba == `DCM_BA_MR1) begin
        mr1_reg <= cmd_s2_reg.addr;
      end else if (cmd_s2_reg.ba == `DCM_BA_MR3) begin
        mr3_reg <= cmd_s2_reg.addr;
      end
    end
  end
  // ----------------------------------------------------------------
  // latency: cl from mode_reg_zero, al from mode_reg_one
  // ----------------------------------------------------------------
  logic [3:0] cl, al, rl;
  logic [1:0] al_code;
  logic lat_bad;
  assign cl = {1'b0, mr0_reg[`DCM_MR0_CL_LSB +: 3]} + `DCM_CL_BASE;
  assign al_code = mr1_reg[`DCM_MR1_AL_LSB +: 2];
  always_comb begin
    if (al_code == `DCM_AL_CLM1) begin
      al = cl - 4'h1;
    end else if (al_code == `DCM_AL_CLM2) begin
      al = cl - 4'h2;
    end else begin
      al = 4'h0;
    end
  end
  // dll-off references output one ck earlier
  assign rl = dll_off ? (al + cl - 4'h1) : (al + cl);
  // only cl six is a legal dll-off latency
  assign lat_bad = dll_off & (cl != `DCM_DLLOFF_CL);
  // ----------------------------------------------------------------
  // self-refresh and power-down: refused during pattern mode
  // ----------------------------------------------------------------
  logic sleep_req;
  assign sleep_req = ck_rise & cke_d_reg & ~cmd_s2_reg.cke &
                     ((op == `DCM_CMD_REF) | (op == `DCM_CMD_NOP));
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cke_d_reg <= 1'b0;
      self_ref_o <= 1'b0;
    end else if (ck_rise) begin
      cke_d_reg <= cmd_s2_reg.cke;
      if (sleep_req && !mpr_en) begin
        self_ref_o <= 1'b1;
      end else if (cmd_s2_reg.cke) begin
        self_ref_o <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // array access: only outside pattern mode
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arr_rd_req <= 1'b0;
      arr_wr_req <= 1'b0;
    end else begin
      arr_rd_req <= rd_fire & ~mpr_en;
      arr_wr_req <= wr_fire & ~mpr_en;
    end
  end
  // ----------------------------------------------------------------
  // read burst sequencer
  // ----------------------------------------------------------------
  dcm_rd_e rd_state;
  logic [3:0] lat_cnt, beat_cnt;
  logic mpr_burst_reg, fill_same_reg;
  logic [15:0] arr_word_reg;
  logic [7:0] rd_count_reg;
  // a second read during a burst is dropped: one read in flight
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_state <= RD_IDLE;
      lat_cnt <= 4'h0;
      beat_cnt <= 4'h0;
      mpr_burst_reg <= 1'b0;
    end else begin
      case (rd_state)
        RD_IDLE: begin
          if (rd_fire) begin
            // autoprecharge bit is not looked at in pattern mode
            lat_cnt <= rl - 4'h1;
            mpr_burst_reg <= mpr_en;
            rd_state <= RD_WAIT;
          end
        end
        RD_WAIT: begin
          if (ck_rise) begin
            if (lat_cnt == 4'h0) begin
              beat_cnt <= 4'h1;
              rd_state <= RD_BURST;
            end else begin
              lat_cnt <= lat_cnt - 4'h1;
            end
          end
        end
        RD_BURST: begin
          if (ck_edge) begin
            if (beat_cnt == `DCM_BEATS) begin
              beat_cnt <= 4'h0;
              rd_state <= RD_IDLE;
            end else begin
              beat_cnt <= beat_cnt + 4'h1;
            end
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end
  // array word held for the burst
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      arr_word_reg <= '0;
    end else if (arr_rd_req) begin
      arr_word_reg <= arr_rd_data;
    end
  end
  // ----------------------------------------------------------------
  // data and strobe outputs
  // ----------------------------------------------------------------
  logic pat_bit;
  logic [7:0] lane_pat;
  logic burst_start, beat_go;
  assign burst_start = (rd_state == RD_WAIT) & ck_rise & (lat_cnt == 4'h0);
  assign beat_go = burst_start |
                   ((rd_state == RD_BURST) & ck_edge & (beat_cnt != `DCM_BEATS));
  // even beats carry zero, odd carry one
  assign pat_bit = burst_start ? 1'b0 : beat_cnt[0];
  assign lane_pat = fill_same_reg ? {8{pat_bit}} : {7'h00, pat_bit};
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dq_o <= '0;
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe <= 1'b0;
    end else if (beat_go) begin
      dq_o <= mpr_burst_reg ? {lane_pat, lane_pat} : arr_word_reg;
      dq_oe <= 1'b1;
      dqs_o <= ~pat_bit;
      dqs_oe <= 1'b1;
    end else if ((rd_state == RD_BURST) && ck_edge) begin
      dq_oe <= 1'b0;
      dqs_o <= 1'b0;
      dqs_oe <= 1'b0;
    end
  end
  // reads seen since reset, wraps
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rd_count_reg <= 8'h00;
    end else if (rd_fire) begin
      rd_count_reg <= rd_count_reg + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // wishbone slave: ack one cycle after request, no waits
  // ----------------------------------------------------------------
  logic wb_req;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      fill_same_reg <= `DCM_CTRL_RST;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 (wb_adr_i == `DCM_ADR_CTRL)) begin
      fill_same_reg <= wb_dat_i[0];
    end
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (!wb_req || wb_we_i) begin
        wb_dat_o <= '0;
      end else if (wb_adr_i == `DCM_ADR_STATUS) begin
        // top three bits read as zero
        wb_dat_o <= {3'h0, rd_count_reg, 4'h0, rl, cl, al, 1'b0,
                     lat_bad, self_ref_o, dll_off, mpr_en};
      end else if (wb_adr_i == `DCM_ADR_CTRL) begin
        wb_dat_o <= {31'h0, fill_same_reg};
      end else if (wb_adr_i == `DCM_ADR_MR0) begin
        wb_dat_o <= {19'h0, mr0_reg};
      end else if (wb_adr_i == `DCM_ADR_MR1) begin
        wb_dat_o <= {19'h0, mr1_reg};
      end else if (wb_adr_i == `DCM_ADR_MR3) begin
        wb_dat_o <= {19'h0, mr3_reg};
      end else begin
        wb_dat_o <= '0;
      end
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_mr3_set;
    mrs_fire && cmd_s2_reg.ba == `DCM_BA_MR3 &&
      cmd_s2_reg.addr[`DCM_MR3_MPR_BIT];
  endsequence
  sequence s_mpr_read;
    rd_fire && mpr_en && rd_state == RD_IDLE;
  endsequence
  a_mpr_enable: assert property (s_mr3_set |=> mpr_en)
    else $error("pattern enable not taken");
  a_mpr_redirect: assert property (s_mpr_read |=> !arr_rd_req ##0
    mpr_burst_reg)
    else $error("pattern read reached array");
  a_array_read: assert property (rd_fire && !mpr_en |=> arr_rd_req)
    else $error("array read missing");
  a_dll_bit: assert property (mrs_fire && cmd_s2_reg.ba == `DCM_BA_MR1
    |=> dll_off == $past(cmd_s2_reg.addr[0]))
    else $error("dll bit not tracked");
  a_read_latency: assert property (rd_fire && rd_state == RD_IDLE |=>
    lat_cnt == (dll_off ? al + cl - 4'h2 : al + cl - 4'h1))
    else $error("read latency wrong");
  a_dlloff_cl: assert property (dll_off && cl != `DCM_DLLOFF_CL
    |-> lat_bad)
    else $error("bad dll-off latency not flagged");
  a_no_sleep: assert property (mpr_en && sleep_req |=>
    $stable(self_ref_o))
    else $error("sleep entered in pattern mode");
  a_pattern_first: assert property (burst_start && mpr_burst_reg |=>
    dq_oe && !dq_o[0] && !dq_o[8])
    else $error("pattern does not start at zero");
endmodule
`default_nettype wire

// ### verilog/dcm_pkg.sv
// Purpose: shared types of the dram mode block
// Assumes: nothing
// Notes: command pins travel as one packed struct
`default_nettype none
package dcm_pkg;
  typedef struct packed {
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] ba;
    logic [12:0] addr;
  } dcm_cmd_s;
  typedef enum logic [2:0] {
    RD_IDLE = 3'b001,
    RD_WAIT = 3'b010,
    RD_BURST = 3'b100
  } dcm_rd_e;
endpackage
`default_nettype wire

// ### verilog/dcm_regs.svh
// Purpose: register map, field positions and counts for the dram mode block
// Assumes: 32-bit classic wishbone, byte addresses
// Notes: definitions only
`ifndef DCM_REGS_SVH
`define DCM_REGS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DCM_ADR_STATUS 8'h00
`define DCM_ADR_CTRL 8'h04
`define DCM_ADR_MR0 8'h08
`define DCM_ADR_MR1 8'h0c
`define DCM_ADR_MR3 8'h10
`define DCM_CTRL_RST 1'h1
// ----------------------------------------------------------------
// mode register fields and command codes {cs_n,ras_n,cas_n,we_n}
// ----------------------------------------------------------------
`define DCM_MR3_MPR_BIT 2
`define DCM_MR1_DLL_BIT 0
`define DCM_MR0_CL_LSB 4
`define DCM_MR1_AL_LSB 3
`define DCM_CL_BASE 4'h4
`define DCM_DLLOFF_CL 4'h6
`define DCM_AL_CLM1 2'h1
`define DCM_AL_CLM2 2'h2
`define DCM_BA_MR0 3'h0
`define DCM_BA_MR1 3'h1
`define DCM_BA_MR3 3'h3
`define DCM_CMD_MRS 4'h0
`define DCM_CMD_REF 4'h1
`define DCM_CMD_WR 4'h4
`define DCM_CMD_RD 4'h5
`define DCM_CMD_NOP 4'h7
`define DCM_BEATS 4'h8
`endif
